// ### pos_io_pkg.sv
// shared constants, register map and carrier types for the positioning axis i/o block
package pos_io_pkg;

  // axis count and input slots
  localparam int NAX      = 2;
  localparam int NIN      = 5;
  localparam int IN_READY = 0;
  localparam int IN_UPPER = 1;
  localparam int IN_LOWER = 2;
  localparam int IN_DOG   = 3;
  localparam int IN_ZERO  = 4;

  // timing: filter unit is one microsecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT_UNIT_NS  = 1000;
  localparam int TICK_CYC      = FILT_UNIT_NS / CLK_PERIOD_NS;
  localparam int DIV_W         = 7;

  // register map, byte addresses
  localparam logic [7:0] AX_STRIDE  = 8'h20;
  localparam logic [7:0] AX_CMD     = 8'h00;
  localparam logic [7:0] AX_CFG     = 8'h04;
  localparam logic [7:0] AX_COUNT   = 8'h08;
  localparam logic [7:0] AX_PERIOD  = 8'h0C;
  localparam logic [7:0] AX_STATUS  = 8'h10;
  localparam logic [7:0] IRQ_STATUS = 8'h40;
  localparam logic [7:0] IRQ_MASK   = 8'h44;

  // command bits (write only, self clearing)
  localparam int CMD_MOVE  = 0;
  localparam int CMD_STOP  = 1;
  localparam int CMD_HOME  = 2;
  localparam int CMD_APPLY = 3;
  localparam int CMD_W     = 4;

  // configuration fields
  localparam int CFG_W         = 16;
  localparam int CFG_DIR       = 0;
  localparam int CFG_RETRY     = 1;
  localparam int CFG_METHOD    = 2;
  localparam int CFG_HOME_DIR  = 4;
  localparam int CFG_USE_READY = 5;
  localparam int CFG_USE_UPPER = 6;
  localparam int CFG_USE_LOWER = 7;
  localparam int CFG_FILT      = 8;
  localparam int FILT_W        = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;

  // homing methods
  localparam logic [1:0] METHOD_DOG     = 2'h0;
  localparam logic [1:0] METHOD_STOPPER = 2'h1;
  localparam logic [1:0] METHOD_COUNT1  = 2'h2;
  localparam logic [1:0] METHOD_COUNT2  = 2'h3;

  // status fields
  localparam int ST_REQ  = 0;
  localparam int ST_DONE = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_ERR  = 3;
  localparam int ST_LVL  = 4;
  localparam int ST_ASG  = 9;

  // interrupt events per axis
  localparam int EV_DOG  = 0;
  localparam int EV_ZERO = 1;
  localparam int EV_STOP = 2;
  localparam int EV_HOME = 3;
  localparam int EV_PER  = 4;
  localparam int IRQ_W   = NAX * EV_PER;

  localparam int CNT_W = 32;
  localparam int PER_W = 16;
  localparam logic [PER_W-1:0] PER_RST = 16'h0031;

  typedef enum logic [1:0] {
    AX_IDLE  = 2'b00,
    AX_MOVE  = 2'b01,
    AX_SEEK  = 2'b10,
    AX_CREEP = 2'b11
  } axst_t;

  // pin groups, bit 0 is drive ready
  typedef struct packed {
    logic zero;
    logic dog;
    logic lower;
    logic upper;
    logic ready;
  } pins_in_t;

  typedef struct packed {
    logic clear;
    logic rev;
    logic fwd;
  } pins_out_t;

endpackage

// ### pos_in_cond.sv
// input conditioner: three-stage synchroniser and response-time filter
`timescale 1ns/1ns
`default_nettype none
module pos_in_cond
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         tick,
  input  wire logic [pos_io_pkg::FILT_W-1:0] filt,
  input  wire logic                         pin,
  output logic                              level,
  output logic                              rise
);
  import pos_io_pkg::*;

  typedef struct packed {
    logic [2:0]        sync;
    logic              lvl;
    logic              rise;
    logic [FILT_W-1:0] cnt;
  } cond_t;

  cond_t q;
  cond_t d;

  always_comb
  begin
    d      = q;
    d.rise = 1'b0;
    // pin high means photocoupler conducting, i.e. on
    d.sync = {q.sync[1:0], pin};
    if ((q.sync[1] == q.sync[2]) && (q.sync[2] != q.lvl))
    begin
      // new level must stay for filt microseconds
      if (q.cnt >= filt)
      begin
        d.lvl  = q.sync[2];
        d.rise = q.sync[2];
        d.cnt  = '0;
      end
      else if (tick)
      begin
        d.cnt = q.cnt + 1'b1;
      end
    end
    else if (q.sync[1] == q.sync[2])
    begin
      d.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign level = q.lvl;
  assign rise  = q.rise;

endmodule
`default_nettype wire

// ### pos_axis_io.sv
// two-axis pulse-train positioning i/o with avalon-mm registers and interrupt
// Summary of operation
// - drive not ready sets homing request flag
// - ready loss stops move; no auto restart
// - ready loss clears homing done flag
// - unassigned ready or limit reads as on
// - dog detected on rising edge only
// - either limit off stops positioning
// - with retry, limits bound dog search
// - clear output while homing, except count two
// - motion as forward or reverse pulses
// - conducting photocoupler reads on, else off
// - error drives outputs to cleared state
// - configurable input response filter time
// - apply settings assigns needed signals
// - independent parameter set per axis
// - zero input rising edge marks origin
// - two identical independent axes
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pos_axis_io
(
  input  wire logic                                       sys_clk,
  input  wire logic                                       rst_n,
  input  wire logic [7:0]                                 avs_address,
  input  wire logic                                       avs_read,
  input  wire logic                                       avs_write,
  input  wire logic [31:0]                                avs_writedata,
  input  wire logic [3:0]                                 avs_byteenable,
  output logic [31:0]                                     avs_readdata,
  output logic                                            avs_waitrequest,
  input  wire pos_io_pkg::pins_in_t [pos_io_pkg::NAX-1:0] pins_in,
  output pos_io_pkg::pins_out_t [pos_io_pkg::NAX-1:0]     pins_out,
  output logic                                            irq
);
  import pos_io_pkg::*;

  typedef struct packed {
    axst_t            st;
    logic [CFG_W-1:0] cfg;
    logic [CNT_W-1:0] cnt;
    logic [PER_W-1:0] per;
    logic [PER_W-1:0] pcnt;
    logic             phase;
    logic             dir_rev;
    logic             req;
    logic             done;
    logic             err;
    logic [NIN-1:0]   asg;
    logic             rdy_prev;
    pins_out_t        out;
  } axis_t;

  typedef struct packed {
    axis_t [NAX-1:0]  ax;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mk;
    logic             ack;
    logic [31:0]      rdata;
    logic [DIV_W-1:0] div;
  } state_t;

  state_t q;
  state_t d;

  logic [NAX-1:0][NIN-1:0] lvl;
  logic [NAX-1:0][NIN-1:0] rise;
  logic                    tick;

  assign tick = (q.div == DIV_W'(TICK_CYC - 1));

  // one conditioner per input per axis
  genvar ga;
  genvar gk;
  generate
    for (ga = 0; ga < NAX; ga++)
    begin : g_ax
      for (gk = 0; gk < NIN; gk++)
      begin : g_in
        pos_in_cond u_cond
        (
          .sys_clk (sys_clk),
          .rst_n   (rst_n),
          .tick    (tick),
          .filt    (q.ax[ga].cfg[CFG_FILT +: FILT_W]),
          .pin     (pins_in[ga][gk]),
          .level   (lvl[ga][gk]),
          .rise    (rise[ga][gk])
        );
      end
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_comb
  begin
    logic [31:0]      wmask;
    logic             wr;
    logic [7:0]       base;
    logic [CMD_W-1:0] cmd;
    logic             rdy;
    logic             up;
    logic             lo;
    logic             busy;
    logic             pdone;
    logic             lim_dir;
    logic [1:0]       meth;
    logic [IRQ_W-1:0] ev;
    logic [31:0]      rd;
    wmask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wr      = avs_write & q.ack;
    base    = 8'h00;
    cmd     = '0;
    rdy     = 1'b0;
    up      = 1'b0;
    lo      = 1'b0;
    busy    = 1'b0;
    pdone   = 1'b0;
    lim_dir = 1'b0;
    meth    = 2'h0;
    ev      = '0;
    rd      = 32'h0000_0000;
    d       = q;

    // one wait cycle per access, answer on the second
    d.ack = (avs_read | avs_write) & ~q.ack;
    d.div = tick ? '0 : DIV_W'(q.div + 1'b1);

    for (int a = 0; a < NAX; a++)
    begin
      base = 8'(a * AX_STRIDE);
      meth = q.ax[a].cfg[CFG_METHOD +: 2];
      // unassigned ready and limit inputs count as permanently on
      rdy  = ~q.ax[a].asg[IN_READY] | lvl[a][IN_READY];
      up   = ~q.ax[a].asg[IN_UPPER] | lvl[a][IN_UPPER];
      lo   = ~q.ax[a].asg[IN_LOWER] | lvl[a][IN_LOWER];
      busy = (q.ax[a].st != AX_IDLE);
      pdone = busy && (q.ax[a].pcnt == '0) && q.ax[a].phase;

      // per-axis parameter registers
      if (wr && (avs_address == base + AX_CFG))
        d.ax[a].cfg = CFG_W'(merge(32'(q.ax[a].cfg), avs_writedata, wmask));
      if (wr && (avs_address == base + AX_COUNT) && !busy)
        d.ax[a].cnt = merge(q.ax[a].cnt, avs_writedata, wmask);
      if (wr && (avs_address == base + AX_PERIOD))
        d.ax[a].per = PER_W'(merge(32'(q.ax[a].per), avs_writedata, wmask));
      cmd  = (wr && (avs_address == base + AX_CMD)) ?
             (avs_writedata[CMD_W-1:0] & wmask[CMD_W-1:0]) : '0;

      if (cmd[CMD_APPLY])
      begin
        // limits are needed whenever retry searches between them
        d.ax[a].asg[IN_READY] = q.ax[a].cfg[CFG_USE_READY];
        d.ax[a].asg[IN_UPPER] = q.ax[a].cfg[CFG_USE_UPPER] | q.ax[a].cfg[CFG_RETRY];
        d.ax[a].asg[IN_LOWER] = q.ax[a].cfg[CFG_USE_LOWER] | q.ax[a].cfg[CFG_RETRY];
        d.ax[a].asg[IN_DOG]   = 1'b1;
        d.ax[a].asg[IN_ZERO]  = 1'b1;
      end

      // half-period pulse generator
      if (busy)
      begin
        if (q.ax[a].pcnt == '0)
        begin
          d.ax[a].pcnt  = q.ax[a].per;
          d.ax[a].phase = ~q.ax[a].phase;
        end
        else
        begin
          d.ax[a].pcnt = q.ax[a].pcnt - 1'b1;
        end
      end

      if (q.ax[a].asg[IN_DOG] && rise[a][IN_DOG])
        ev[a*EV_PER + EV_DOG] = 1'b1;
      if (q.ax[a].asg[IN_ZERO] && rise[a][IN_ZERO])
        ev[a*EV_PER + EV_ZERO] = 1'b1;

      case (q.ax[a].st)
        AX_IDLE:
        begin
          d.ax[a].phase = 1'b0;
          d.ax[a].pcnt  = q.ax[a].per;
          if (cmd[CMD_MOVE] && rdy && up && lo && (q.ax[a].cnt != '0))
          begin
            d.ax[a].st      = AX_MOVE;
            d.ax[a].dir_rev = q.ax[a].cfg[CFG_DIR];
            d.ax[a].err     = 1'b0;
          end
          else if (cmd[CMD_HOME] && rdy)
          begin
            d.ax[a].st      = AX_SEEK;
            d.ax[a].dir_rev = q.ax[a].cfg[CFG_HOME_DIR];
            d.ax[a].done    = 1'b0;
            d.ax[a].err     = 1'b0;
          end
        end
        AX_MOVE:
        begin
          if (pdone)
          begin
            d.ax[a].cnt = q.ax[a].cnt - 1'b1;
            if (q.ax[a].cnt == CNT_W'(1))
              d.ax[a].st = AX_IDLE;
          end
          if (!up || !lo)
          begin
            d.ax[a].st  = AX_IDLE;
            d.ax[a].err = 1'b1;
            ev[a*EV_PER + EV_STOP] = 1'b1;
          end
        end
        AX_SEEK, AX_CREEP:
        begin
          // dog counts only on its off-to-on edge
          if ((q.ax[a].st == AX_SEEK) && ev[a*EV_PER + EV_DOG])
            d.ax[a].st = AX_CREEP;
          if ((q.ax[a].st == AX_CREEP) && ev[a*EV_PER + EV_ZERO])
          begin
            d.ax[a].st   = AX_IDLE;
            d.ax[a].done = 1'b1;
            d.ax[a].req  = 1'b0;
            ev[a*EV_PER + EV_HOME] = 1'b1;
          end
          lim_dir = q.ax[a].dir_rev ? ~lo : ~up;
          if (q.ax[a].cfg[CFG_RETRY])
          begin
            // turn back at the limit ahead; the one behind is ignored
            if (lim_dir && (d.ax[a].st != AX_IDLE))
            begin
              d.ax[a].dir_rev = ~q.ax[a].dir_rev;
              d.ax[a].st      = AX_SEEK;
            end
          end
          else if (!up || !lo)
          begin
            d.ax[a].st  = AX_IDLE;
            d.ax[a].err = 1'b1;
            ev[a*EV_PER + EV_STOP] = 1'b1;
          end
        end
        default:
        begin
          d.ax[a].st = AX_IDLE;
        end
      endcase

      if (busy && cmd[CMD_STOP])
        d.ax[a].st = AX_IDLE;

      // ready loss: back to idle; a fresh start command is required
      if (!rdy)
      begin
        d.ax[a].req = 1'b1;
        if (busy)
        begin
          d.ax[a].st  = AX_IDLE;
          d.ax[a].err = 1'b1;
          ev[a*EV_PER + EV_STOP] = 1'b1;
        end
      end
      if (q.ax[a].rdy_prev && !rdy)
        d.ax[a].done = 1'b0;
      d.ax[a].rdy_prev = rdy;

      // idle or error leaves every output cleared
      d.ax[a].out.fwd   = (d.ax[a].st != AX_IDLE) & d.ax[a].phase & ~d.ax[a].dir_rev;
      d.ax[a].out.rev   = (d.ax[a].st != AX_IDLE) & d.ax[a].phase & d.ax[a].dir_rev;
      d.ax[a].out.clear = ((d.ax[a].st == AX_SEEK) || (d.ax[a].st == AX_CREEP))
                          && (meth != METHOD_COUNT2);

      if (avs_address == base + AX_CFG)
        rd = 32'(q.ax[a].cfg);
      if (avs_address == base + AX_COUNT)
        rd = q.ax[a].cnt;
      if (avs_address == base + AX_PERIOD)
        rd = 32'(q.ax[a].per);
      if (avs_address == base + AX_STATUS)
      begin
        rd[ST_REQ]              = q.ax[a].req;
        rd[ST_DONE]             = q.ax[a].done;
        rd[ST_BUSY]             = busy;
        rd[ST_ERR]              = q.ax[a].err;
        rd[ST_LVL +: NIN]       = {lvl[a][IN_ZERO], lvl[a][IN_DOG], lo, up, rdy};
        rd[ST_ASG +: NIN]       = q.ax[a].asg;
      end
    end

    // sticky events: a new event wins over a same-cycle clear
    if (wr && (avs_address == IRQ_STATUS))
      d.irq_st = (q.irq_st & ~(avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0])) | ev;
    else
      d.irq_st = q.irq_st | ev;
    if (wr && (avs_address == IRQ_MASK))
      d.irq_mk = IRQ_W'(merge(32'(q.irq_mk), avs_writedata, wmask));

    if (avs_address == IRQ_STATUS)
      rd = 32'(q.irq_st);
    if (avs_address == IRQ_MASK)
      rd = 32'(q.irq_mk);

    // read data captured in the wait cycle, stands through the answer
    if (avs_read && !q.ack)
      d.rdata = rd;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      for (int a = 0; a < NAX; a++)
      begin
        q.ax[a].cfg <= CFG_RST;
        q.ax[a].per <= PER_RST;
        q.ax[a].req <= 1'b1;
      end
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
  assign avs_readdata    = q.rdata;
  assign irq             = |(q.irq_st & q.irq_mk);

  always_comb
  begin
    for (int a = 0; a < NAX; a++)
      pins_out[a] = q.ax[a].out;
  end

endmodule
`default_nettype wire

// ### pos_axis_io_asserts.sv
// port-level property checks for the positioning i/o block
`timescale 1ns/1ns
`default_nettype none
module pos_axis_io_chk
(
  input wire logic                                        sys_clk,
  input wire logic                                        rst_n,
  input wire logic                                        avs_read,
  input wire logic                                        avs_write,
  input wire logic [31:0]                                 avs_readdata,
  input wire logic                                        avs_waitrequest,
  input wire pos_io_pkg::pins_out_t [pos_io_pkg::NAX-1:0] pins_out,
  input wire logic                                        irq
);
  import pos_io_pkg::*;
  logic rw;
  assign rw = avs_read | avs_write;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_dir_excl0: assert property (!(pins_out[0].fwd && pins_out[0].rev))
    else $error("both pulse outputs high on axis 0");
  a_dir_excl1: assert property (!(pins_out[1].fwd && pins_out[1].rev))
    else $error("both pulse outputs high on axis 1");
  a_wait_first: assert property (rw && !$past(rw) |-> avs_waitrequest)
    else $error("no wait cycle on a new request");
  a_wait_one: assert property (rw && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait lasted more than one cycle");
  a_wait_idle: assert property (!rw |-> !avs_waitrequest)
    else $error("wait raised without a request");
  a_rdata_hold: assert property (!$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_clear_start: assert property ($rose(pins_out[0].clear) |-> !pins_out[0].fwd && !pins_out[0].rev)
    else $error("pulses active when clear rose");
  a_clear_end: assert property ($fell(pins_out[0].clear) |-> pins_out[0] == 3'h0)
    else $error("outputs active when clear fell");
  a_out_reset: assert property ($rose(rst_n) |-> pins_out == '0 && !irq)
    else $error("outputs not quiet after reset");
  c_pulse: cover property ($rose(pins_out[0].fwd));
  c_clear: cover property ($rose(pins_out[0].clear));
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ### pos_drive_model.sv
// drive unit and switch model: passes switch levels, counts pulses and droop
`timescale 1ns/1ns
`default_nettype none
module pos_drive_model
(
  input  wire logic                                        sys_clk,
  input  wire logic                                        rst_n,
  input  wire pos_io_pkg::pins_out_t [pos_io_pkg::NAX-1:0] pins_out,
  input  wire pos_io_pkg::pins_in_t [pos_io_pkg::NAX-1:0]  sw,
  output pos_io_pkg::pins_in_t [pos_io_pkg::NAX-1:0]       pins_in,
  output logic [1:0][15:0]                                 fwd_cnt,
  output logic [1:0][15:0]                                 rev_cnt,
  output logic [1:0][15:0]                                 droop
);
  import pos_io_pkg::*;
  pins_out_t [NAX-1:0] last_q;
  // closed contact conducts, so a one on the wire
  assign pins_in = sw;
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_q <= '0;
      fwd_cnt <= '0;
      rev_cnt <= '0;
      droop <= '0;
    end
    else
    begin
      last_q <= pins_out;
      for (int a = 0; a < NAX; a++)
      begin
        if (pins_out[a].fwd && !last_q[a].fwd)
          fwd_cnt[a] <= fwd_cnt[a] + 16'h1;
        if (pins_out[a].rev && !last_q[a].rev)
          rev_cnt[a] <= rev_cnt[a] + 16'h1;
        // droop only drains while clear is held
        if (pins_out[a].clear)
          droop[a] <= 16'h0;
        else if (pins_out[a].fwd && !last_q[a].fwd)
          droop[a] <= droop[a] + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### positioning_axis_signal_io_bench.sv
// self-checking bench for the two-axis positioning i/o block
`timescale 1ns/1ns
`default_nettype none
module positioning_axis_signal_io_bench;
  import pos_io_pkg::*;
  typedef struct packed {logic [7:0] addr; logic [31:0] mask; logic [31:0] exp;} row_t;
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         avs_address = 8'h00;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  pins_in_t [NAX-1:0] pins_in;
  pins_in_t [NAX-1:0] sw = {2{5'h07}};
  pins_out_t [NAX-1:0] pins_out;
  logic               irq;
  logic [1:0][15:0]   fwd_cnt;
  logic [1:0][15:0]   rev_cnt;
  logic [1:0][15:0]   droop;
  int                 err_total = 0;
  int                 num_checks = 0;
  int                 cyc = 0;
  logic [31:0]        q;
  logic [15:0]        f0;
  logic [15:0]        r0;
  logic [7:0]         b;
  row_t rows [11] = '{'{8'h00, 32'hFFFFFFFF, 32'h0}, '{8'h04, 32'hFFFFFFFF, 32'h0},
    '{8'h0C, 32'hFFFFFFFF, 32'h31}, '{8'h10, 32'h3FFF, 32'h71}, '{8'h20, 32'hFFFFFFFF, 32'h0},
    '{8'h24, 32'hFFFFFFFF, 32'h0}, '{8'h2C, 32'hFFFFFFFF, 32'h31}, '{8'h30, 32'h3FFF, 32'h71},
    '{8'h40, 32'hFFFFFFFF, 32'h0}, '{8'h44, 32'hFFFFFFFF, 32'h0}, '{8'h80, 32'hFFFFFFFF, 32'h0}};
  pos_axis_io uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pins_in(pins_in), .pins_out(pins_out), .irq(irq));
  pos_drive_model drv (.sys_clk(sys_clk), .rst_n(rst_n), .pins_out(pins_out), .sw(sw),
    .pins_in(pins_in), .fwd_cnt(fwd_cnt), .rev_cnt(rev_cnt), .droop(droop));
  always #5 sys_clk = ~sys_clk;
  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one request, held until wait drops; released a full cycle before the next
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // wait and read data are taken at the rising edge, before it updates them
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q & m, e);
  endtask
  task automatic wait_idle(input logic [7:0] a);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, a + 8'h10, 32'h0);
      n++;
    end
    while (q[ST_BUSY] !== 1'b0 && n < 100);
    chk("idle", 32'(q[ST_BUSY]), 32'h0);
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[i])
      rdchk("reg", rows[i].addr, rows[i].mask, rows[i].exp);
    for (int a = 0; a < NAX; a++)
    begin
      b = 8'(a * 32);
      bus(1'b1, b + 8'h04, 32'h00E0 | a);
      bus(1'b1, b + 8'h0C, 32'h1);
      bus(1'b1, b + 8'h08, 32'h3);
      bus(1'b1, b, 32'h8);
      rdchk("assign", b + 8'h10, 32'hE00, 32'hE00);
      f0 = fwd_cnt[a];
      r0 = rev_cnt[a];
      bus(1'b1, b, 32'h1);
      wait_idle(b);
      chk("fwd", 32'(fwd_cnt[a] - f0), a ? 32'h0 : 32'h3);
      chk("rev", 32'(rev_cnt[a] - r0), a ? 32'h3 : 32'h0);
    end
    bus(1'b1, 8'h44, 32'hFF);
    for (int l = 0; l < 2; l++)
    begin
      bus(1'b1, 8'h04, 32'h00E0);
      bus(1'b1, 8'h08, 32'h64);
      bus(1'b1, 8'h00, 32'h1);
      repeat (10) @(posedge sys_clk);
      sw[0] <= l ? 5'h03 : 5'h05;
      repeat (20) @(posedge sys_clk);
      chk("lim_outs", 32'(pins_out[0]), 32'h0);
      rdchk("lim_stop", 8'h10, 32'hC, 32'h8);
      bus(1'b1, 8'h00, 32'h1);
      rdchk("lim_refuse", 8'h10, 32'h4, 32'h0);
      chk("irq_set", 32'(irq), 32'h1);
      bus(1'b1, 8'h40, 32'h4);
      chk("irq_clr", 32'(irq), 32'h0);
      sw[0] <= 5'h07;
      repeat (10) @(posedge sys_clk);
    end
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, 8'h04, 32'h00E0 | (m << 2));
      bus(1'b1, 8'h00, 32'h8);
      bus(1'b1, 8'h00, 32'h4);
      repeat (8) @(posedge sys_clk);
      chk("clear", 32'(pins_out[0].clear), 32'(m != 3));
      chk("iso", 32'(pins_out[1]), 32'h0);
      sw[0] <= 5'h0F;
      repeat (8) @(posedge sys_clk);
      sw[0] <= 5'h1F;
      repeat (8) @(posedge sys_clk);
      rdchk("home", 8'h10, 32'hF, 32'h2);
      if (m != 3)
        chk("droop", 32'(droop[0]), 32'h0);
      rdchk("home_irq", 8'h40, 32'h9, 32'h9);
      bus(1'b1, 8'h40, 32'hF);
      sw[0] <= 5'h07;
      repeat (8) @(posedge sys_clk);
    end
    bus(1'b1, 8'h08, 32'h64);
    bus(1'b1, 8'h00, 32'h1);
    repeat (10) @(posedge sys_clk);
    sw[0] <= 5'h06;
    repeat (20) @(posedge sys_clk);
    rdchk("rdy_loss", 8'h10, 32'hF, 32'h9);
    chk("rdy_outs", 32'(pins_out[0]), 32'h0);
    chk("irq_rdy", 32'(irq), 32'h1);
    bus(1'b1, 8'h44, 32'h0);
    chk("irq_mask", 32'(irq), 32'h0);
    sw[0] <= 5'h07;
    f0 = fwd_cnt[0];
    repeat (30) @(posedge sys_clk);
    rdchk("no_restart", 8'h10, 32'hF, 32'h9);
    chk("no_pulse", 32'(fwd_cnt[0] - f0), 32'h0);
    // retry homing turns back at the limit ahead, then a stop command ends it
    bus(1'b1, 8'h04, 32'h00E2);
    bus(1'b1, 8'h00, 32'h8);
    bus(1'b1, 8'h00, 32'h4);
    repeat (8) @(posedge sys_clk);
    r0 = rev_cnt[0];
    sw[0] <= 5'h05;
    repeat (20) @(posedge sys_clk);
    rdchk("retry", 8'h10, 32'hC, 32'h4);
    chk("retry_rev", 32'(rev_cnt[0] != r0), 32'h1);
    bus(1'b1, 8'h00, 32'h2);
    rdchk("stop", 8'h10, 32'hC, 32'h0);
    chk("stop_outs", 32'(pins_out[0]), 32'h0);
    sw[0] <= 5'h07;
    repeat (10) @(posedge sys_clk);
    // two microsecond filter: a short wait must not yet show the new level
    bus(1'b1, 8'h04, 32'h02E0);
    bus(1'b1, 8'h00, 32'h8);
    sw[0] <= 5'h05;
    repeat (20) @(posedge sys_clk);
    rdchk("filt_hold", 8'h10, 32'h20, 32'h20);
    repeat (300) @(posedge sys_clk);
    rdchk("filt_pass", 8'h10, 32'h20, 32'h0);
    sw[0] <= 5'h07;
    // second reset in mid-run must restore the defaults
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk("rst_cfg", 8'h04, 32'hFFFF, 32'h0);
    rdchk("rst_st", 8'h10, 32'h3FFF, 32'h71);
    print_verdict();
  end
endmodule
bind pos_axis_io pos_axis_io_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pins_out(pins_out), .irq(irq));
`default_nettype wire
